// [logic/analog_out_failsafe_defines.vh]
// Purpose: Constants for the two-channel analog output fail-safe control
// Assumes: 100 MHz module clock
// Notes:   Configuration indices apply to the cfg write port
`ifndef ANALOG_OUT_FAILSAFE_DEFINES_VH
`define ANALOG_OUT_FAILSAFE_DEFINES_VH

// ****************************************
// Configuration indices
// ****************************************
`define CFG_CHAN1_SUBST_MODE   4'h0
`define CFG_CHAN2_SUBST_MODE   4'h1
`define CFG_CHAN1_SUBST_VALUE  4'h2
`define CFG_CHAN2_SUBST_VALUE  4'h3
`define CFG_WATCHDOG_LIMIT     4'h4

// ****************************************
// Field positions and values
// ****************************************
`define VALID_BIT              0
`define HEALTH_OPEN_LINE_BIT   2
`define HEALTH_OVERTEMP_BIT    3
`define HEALTH_SUPPLY_BIT      7
`define MODE_STATIC            1'b0
`define MODE_HOLD              1'b1

// ****************************************
// Reset values
// ****************************************
`define RST_VALUE16            16'h0000
`define RST_MODE               1'b0
`define RST_WATCHDOG_LIMIT     16'h0003

// ****************************************
// Timing
// ****************************************
`define CLOCK_PERIOD_NS        10
`define MIN_CYCLE_TIME_NS      200000
`define MIN_CYCLE_CYCLES       (`MIN_CYCLE_TIME_NS / `CLOCK_PERIOD_NS)

`endif

// [logic/analog_out_failsafe_ctrl.v]
// Purpose: Output value, health and fail-safe substitution for two channels
// Assumes: One cyclic transfer pulse per bus cycle from the bus side
// Notes:   Converter, ramp and scaling sit outside this block
//
// Behaviour
// - Zero output value switches channel LED off
// - Health byte: open line, overtemp, supply
// - Substitute mode: 0 static, 1 hold
// - Module valid bit 0; others read zero
// - Valid set: output follows cyclic value
// - Fail-safe event clears valid, substitutes output
// - Static mode outputs configured replacement value
// - Hold mode keeps last valid value
// - Only set valid bit transfer exits fail-safe
// - Next good transfer restores valid bit
// - Replacement value used only after valid set
// - Module health bit shows normal or fail-safe
// - Update completes every bus cycle
// - Two independent channels, separate registers
// - Permissible value drives channel output
`include "analog_out_failsafe_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module analog_out_failsafe_ctrl
#(
  parameter MIN_CYCLE_COUNT = `MIN_CYCLE_CYCLES
)
(
  input  wire        clock,
  input  wire        srst,
  input  wire        xfer_strobe,
  input  wire [15:0] xfer_chan1_value,
  input  wire [15:0] xfer_chan2_value,
  input  wire [7:0]  xfer_valid_ctrl,
  input  wire        cfg_we,
  input  wire [3:0]  cfg_addr,
  input  wire [15:0] cfg_wdata,
  input  wire [1:0]  open_line_in,
  input  wire [1:0]  overtemp_in,
  input  wire        supply_fault_in,
  output wire [15:0] chan1_drive,
  output wire [15:0] chan2_drive,
  output wire [1:0]  channel_led,
  output wire [7:0]  chan1_health,
  output wire [7:0]  chan2_health,
  output wire [7:0]  failsafe_valid_ctrl,
  output reg         module_health_bit,
  output reg         fail_safe_output_mode
);

  // ****************************************
  // Helpers
  // ****************************************
  function [7:0] health_byte;
    input open_line;
    input overtemp;
    input supply;
    begin
      health_byte = 8'h00;
      health_byte[`HEALTH_OPEN_LINE_BIT] = open_line;
      health_byte[`HEALTH_OVERTEMP_BIT]  = overtemp;
      health_byte[`HEALTH_SUPPLY_BIT]    = supply;
    end
  endfunction

  function cfg_hit;
    input       we;
    input [3:0] addr;
    input [3:0] index;
    begin
      if (!we)
      begin
        cfg_hit = 1'b0;
      end
      else if (addr == index)
      begin
        cfg_hit = 1'b1;
      end
      else
      begin
        cfg_hit = 1'b0;
      end
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg  [4:0]  pin_meta;
  reg  [4:0]  pin_sync;

  always @(posedge clock)
  begin
    if (srst)
    begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end
    else
    begin
      pin_meta <= {supply_fault_in, overtemp_in, open_line_in};
      pin_sync <= pin_meta;
    end
  end

  // ****************************************
  // Watchdog on cyclic transfers
  // ****************************************
  reg  [31:0] prescale;
  reg  [15:0] watchdog_ticks;
  reg  [15:0] watchdog_limit;
  reg         valid_int;
  reg  [7:0]  valid_reg;
  wire        tick;
  wire        timeout;

  assign tick    = (prescale == MIN_CYCLE_COUNT - 1);
  assign timeout = tick && (watchdog_limit != 16'h0000) &&
                   (watchdog_ticks + 16'h0001 >= watchdog_limit);

  always @(posedge clock)
  begin
    if (srst)
    begin
      prescale       <= 32'h0000_0000;
      watchdog_ticks <= 16'h0000;
    end
    else if (xfer_strobe)
    begin
      prescale       <= 32'h0000_0000;
      watchdog_ticks <= 16'h0000;
    end
    else if (tick)
    begin
      prescale <= 32'h0000_0000;
      if (watchdog_ticks != 16'hFFFF)
      begin
        watchdog_ticks <= watchdog_ticks + 16'h0001;
      end
    end
    else
    begin
      prescale <= prescale + 32'h0000_0001;
    end
  end

  // ****************************************
  // Module valid bit and mode
  // ****************************************
  localparam [1:0] ST_FAILSAFE = 2'b01;
  localparam [1:0] ST_NORMAL   = 2'b10;

  reg  [1:0]  mode_state;
  reg  [1:0]  next_mode_state;
  wire        next_normal;

  always @*
  begin
    next_mode_state = mode_state;
    case (mode_state)
      ST_NORMAL:
      begin
        if (xfer_strobe)
        begin
          if (!xfer_valid_ctrl[`VALID_BIT])
          begin
            next_mode_state = ST_FAILSAFE;
          end
        end
        else if (timeout)
        begin
          next_mode_state = ST_FAILSAFE;
        end
      end
      ST_FAILSAFE:
      begin
        if (xfer_strobe && xfer_valid_ctrl[`VALID_BIT])
        begin
          next_mode_state = ST_NORMAL;
        end
      end
      default:
      begin
        next_mode_state = ST_FAILSAFE;
      end
    endcase
  end

  assign next_normal = (next_mode_state == ST_NORMAL);

  always @(posedge clock)
  begin
    if (srst)
    begin
      mode_state            <= ST_FAILSAFE;
      valid_int             <= 1'b0;
      valid_reg             <= 8'h00;
      module_health_bit     <= 1'b0;
      fail_safe_output_mode <= 1'b1;
    end
    else
    begin
      mode_state            <= next_mode_state;
      valid_int             <= next_normal;
      valid_reg             <= {7'h00, next_normal};
      module_health_bit     <= next_normal;
      fail_safe_output_mode <= ~next_normal;
    end
  end

  assign failsafe_valid_ctrl = valid_reg;

  always @(posedge clock)
  begin
    if (srst)
    begin
      watchdog_limit <= `RST_WATCHDOG_LIMIT;
    end
    else if (cfg_hit(cfg_we, cfg_addr, `CFG_WATCHDOG_LIMIT))
    begin
      watchdog_limit <= cfg_wdata;
    end
  end

  // ****************************************
  // Per-channel datapath
  // ****************************************
  wire [31:0] drive_bus;
  wire [1:0]  led_bus;
  wire [15:0] health_bus;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : chan
      localparam [3:0] MODE_INDEX  = (ch == 0) ? `CFG_CHAN1_SUBST_MODE :
                                                 `CFG_CHAN2_SUBST_MODE;
      localparam [3:0] VALUE_INDEX = (ch == 0) ? `CFG_CHAN1_SUBST_VALUE :
                                                 `CFG_CHAN2_SUBST_VALUE;

      reg  [15:0] out_value;
      reg  [15:0] last_valid;
      reg  [15:0] subst_pending;
      reg  [15:0] subst_active;
      reg  [15:0] drive;
      reg         subst_mode;
      reg         led;
      reg  [7:0]  health;
      wire [15:0] xfer_value;
      wire        take;
      wire [15:0] next_drive;

      assign xfer_value = (ch == 0) ? xfer_chan1_value : xfer_chan2_value;
      assign take       = xfer_strobe && xfer_valid_ctrl[`VALID_BIT];
      assign next_drive = valid_int ? out_value :
                          (subst_mode == `MODE_HOLD) ? last_valid :
                          subst_active;

      always @(posedge clock)
      begin
        if (srst)
        begin
          out_value     <= `RST_VALUE16;
          last_valid    <= `RST_VALUE16;
          subst_pending <= `RST_VALUE16;
          subst_active  <= `RST_VALUE16;
          drive         <= `RST_VALUE16;
          subst_mode    <= `RST_MODE;
          led           <= 1'b0;
          health        <= 8'h00;
        end
        else
        begin
          if (xfer_strobe)
          begin
            out_value <= xfer_value;
          end
          if (take)
          begin
            last_valid <= xfer_value;
          end
          if (cfg_hit(cfg_we, cfg_addr, MODE_INDEX))
          begin
            subst_mode <= cfg_wdata[0];
          end
          if (cfg_hit(cfg_we, cfg_addr, VALUE_INDEX))
          begin
            subst_pending <= cfg_wdata;
          end
          if (valid_int)
          begin
            subst_active <= subst_pending;
          end
          drive  <= next_drive;
          led    <= (next_drive != 16'h0000);
          health <= health_byte(pin_sync[ch],
                                pin_sync[ch + 2],
                                pin_sync[4]);
        end
      end

      assign drive_bus[ch*16 +: 16] = drive;
      assign led_bus[ch]            = led;
      assign health_bus[ch*8 +: 8]  = health;
    end
  endgenerate

  assign chan1_drive  = drive_bus[15:0];
  assign chan2_drive  = drive_bus[31:16];
  assign channel_led  = led_bus;
  assign chan1_health = health_bus[7:0];
  assign chan2_health = health_bus[15:8];

endmodule

`default_nettype wire

// [verification/analog_out_failsafe_chk.sv]
// Purpose: Port checks of the fail-safe control
// Assumes: One clock
// Notes:   Bound in tb_top
`timescale 1ns/1ps
`default_nettype none
module analog_out_failsafe_chk
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        xfer_strobe,
  input wire logic [15:0] xfer_chan1_value,
  input wire logic [7:0]  xfer_valid_ctrl,
  input wire logic [15:0] chan1_drive,
  input wire logic [1:0]  channel_led,
  input wire logic [7:0]  failsafe_valid_ctrl,
  input wire logic        module_health_bit,
  input wire logic        fail_safe_output_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire ok = xfer_strobe && xfer_valid_ctrl[0];
  wire mh = module_health_bit;
  property p_led; channel_led[0] == |chan1_drive; endproperty
  a_led: assert property (p_led) else $error("led");
  property p_mod; fail_safe_output_mode != mh; endproperty
  a_mod: assert property (p_mod) else $error("mode");
  property p_rsv; failsafe_valid_ctrl[7:1] == 7'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_vb; failsafe_valid_ctrl[0] == mh; endproperty
  a_vb: assert property (p_vb) else $error("valid");
  property p_ok; ok |=> mh; endproperty
  a_ok: assert property (p_ok) else $error("resume");
  property p_fs; xfer_strobe && !xfer_valid_ctrl[0] |=> !mh; endproperty
  a_fs: assert property (p_fs) else $error("failsafe");
  property p_drv; ok |-> ##2 chan1_drive == $past(xfer_chan1_value, 2);
  endproperty
  a_drv: assert property (p_drv) else $error("drive");
  property p_sty; !mh && !ok |=> !mh; endproperty
  a_sty: assert property (p_sty) else $error("stay");
  c_ok: cover property ($rose(mh));
  c_fs: cover property ($fell(mh));
  c_on: cover property (ok ##2 channel_led[0]);
endmodule
`default_nettype wire

// [verification/bus_master_model.sv]
// Purpose: Master model sending cyclic transfers
// Assumes: One transfer every 8 clocks
// Notes:   Idle data lines show inverted values
`timescale 1ns/1ps
`default_nettype none
module bus_master_model
(
  input  wire logic        clock,
  input  wire logic        run,
  input  wire logic        vb,
  input  wire logic [15:0] v1,
  input  wire logic [15:0] v2,
  output wire logic        xfer_strobe,
  output wire logic [15:0] xfer_chan1_value,
  output wire logic [15:0] xfer_chan2_value,
  output wire logic [7:0]  xfer_valid_ctrl
);
  logic [2:0] cnt = 3'h0;
  logic       strobe_q = 1'b0;
  always @(posedge clock)
  begin
    cnt      <= cnt + 3'h1;
    strobe_q <= run && cnt == 3'h0;
  end
  assign xfer_strobe = strobe_q;
  assign xfer_chan1_value = xfer_strobe ? v1 : ~v1;
  assign xfer_chan2_value = xfer_strobe ? v2 : ~v2;
  assign xfer_valid_ctrl = xfer_strobe ? {7'h00, vb} : 8'hFE;
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Purpose: Bench for the fail-safe control
// Assumes: Prescale of 8 clocks
// Notes:   Checker bound at the foot
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clock = 1'b0, srst = 1'b1, run = 1'b0, vb = 1'b0;
  logic        cfg_we = 1'b0, supply_fault_in = 1'b0, xfer_strobe;
  logic        module_health_bit, fail_safe_output_mode;
  logic [1:0]  open_line_in = 2'h0, overtemp_in = 2'h0, channel_led;
  logic [3:0]  cfg_addr = 4'h0;
  logic [7:0]  xfer_valid_ctrl, chan1_health, chan2_health;
  logic [7:0]  failsafe_valid_ctrl;
  logic [15:0] v1 = 16'h0000, v2 = 16'h0000, cfg_wdata = 16'h0000;
  logic [15:0] xfer_chan1_value, xfer_chan2_value, chan1_drive, chan2_drive;
  integer      failures = 0, cmp_count = 0;
  analog_out_failsafe_ctrl #(.MIN_CYCLE_COUNT(8))
    u_analog_out_failsafe_ctrl
    (
      .clock                 (clock),
      .srst                  (srst),
      .xfer_strobe           (xfer_strobe),
      .xfer_chan1_value      (xfer_chan1_value),
      .xfer_chan2_value      (xfer_chan2_value),
      .xfer_valid_ctrl       (xfer_valid_ctrl),
      .cfg_we                (cfg_we),
      .cfg_addr              (cfg_addr),
      .cfg_wdata             (cfg_wdata),
      .open_line_in          (open_line_in),
      .overtemp_in           (overtemp_in),
      .supply_fault_in       (supply_fault_in),
      .chan1_drive           (chan1_drive),
      .chan2_drive           (chan2_drive),
      .channel_led           (channel_led),
      .chan1_health          (chan1_health),
      .chan2_health          (chan2_health),
      .failsafe_valid_ctrl   (failsafe_valid_ctrl),
      .module_health_bit     (module_health_bit),
      .fail_safe_output_mode (fail_safe_output_mode)
    );
  bus_master_model u_bus_master_model
  (
    .clock            (clock),
    .run              (run),
    .vb               (vb),
    .v1               (v1),
    .v2               (v2),
    .xfer_strobe      (xfer_strobe),
    .xfer_chan1_value (xfer_chan1_value),
    .xfer_chan2_value (xfer_chan2_value),
    .xfer_valid_ctrl  (xfer_valid_ctrl)
  );
  task chk(input logic [17:0] got, exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task set(input logic r, b, input logic [15:0] a, c, input integer n);
    @(posedge clock);
    {run, vb, v1, v2} <= {r, b, a, c};
    repeat (n) @(posedge clock);
    #1;
  endtask
  task cfg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    {cfg_we, cfg_addr, cfg_wdata} <= {1'b1, a, d};
    @(posedge clock);
    cfg_we <= 1'b0;
  endtask
  task t_start;
    chk({module_health_bit, fail_safe_output_mode}, 18'h1);
    @(posedge clock);
    {open_line_in, overtemp_in, supply_fault_in} <= 5'b01101;
    cfg(4'h0, 16'h0000);
    cfg(4'h1, 16'h0001);
    cfg(4'h2, 16'h55AA);
    set(1'b1, 1'b1, 16'h1234, 16'h0777, 20);
    chk({chan1_health, chan2_health}, 18'h8488);
    chk(chan1_drive, 18'h1234);
    chk(chan2_drive, 18'h0777);
    chk({failsafe_valid_ctrl, module_health_bit}, 18'h3);
  endtask
  task t_drop;
    set(1'b0, 1'b1, 16'h4321, 16'h0999, 50);
    chk({module_health_bit, chan1_drive}, 18'h055AA);
    chk(chan2_drive, 18'h0777);
    cfg(4'h2, 16'hAAAA);
    set(1'b1, 1'b0, 16'h4321, 16'h0999, 20);
    chk({module_health_bit, chan1_drive}, 18'h055AA);
    set(1'b1, 1'b1, 16'h0000, 16'h0999, 20);
    chk({channel_led, chan2_drive}, 18'h20999);
    set(1'b0, 1'b1, 16'h0000, 16'h0999, 50);
    chk(chan1_drive, 18'hAAAA);
  endtask
  task complete_run;
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial forever #5 clock = ~clock;
  initial
  begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    t_start;
    t_drop;
    complete_run;
  end
  initial
  begin
    #20000;
    failures = failures + 1;
    complete_run;
  end
endmodule
bind analog_out_failsafe_ctrl analog_out_failsafe_chk
  u_analog_out_failsafe_chk
  (
    .clock                 (clock),
    .srst                  (srst),
    .xfer_strobe           (xfer_strobe),
    .xfer_chan1_value      (xfer_chan1_value),
    .xfer_valid_ctrl       (xfer_valid_ctrl),
    .chan1_drive           (chan1_drive),
    .channel_led           (channel_led),
    .failsafe_valid_ctrl   (failsafe_valid_ctrl),
    .module_health_bit     (module_health_bit),
    .fail_safe_output_mode (fail_safe_output_mode)
  );
`default_nettype wire
